// >>> wake_syn_arp_map.vh
// Purpose : Constants for the suspend-time SYN and ARP frame matcher
// Assumes : APB byte addresses, 32-bit data, one word per register
// Notes   : Included by the event register and matcher design files, not the field comparator
`ifndef WAKE_SYN_ARP_MAP_VH
`define WAKE_SYN_ARP_MAP_VH

// ***************************************************************
// Register byte offsets
// ***************************************************************
`define V6_SYN_PORT_OFS      12'h6bc
`define ARP_SENDER_OFS       12'h6c0
`define ARP_TARGET_OFS       12'h6c4
`define WAKE_CTRL_TWO_OFS    12'h6c8
`define WAKE_STATUS_OFS      12'h6cc
`define WAKE_CLEAR_OFS       12'h6d0
`define WAKE_ENABLE_OFS      12'h6d4

// ***************************************************************
// Field positions
// ***************************************************************
`define DEST_PORT_HI         31
`define DEST_PORT_LO         16
`define SRC_PORT_HI          15
`define SRC_PORT_LO          0
`define CTRL_SYN_WAKE_BIT    0
`define CTRL_ARP_OFFLOAD_BIT 1
`define EVT_SYN_BIT          0
`define EVT_ARP_BIT          1
`define EVT_W                2

// ***************************************************************
// Reset values
// ***************************************************************
`define V6_SYN_PORT_RST      32'h0000_0000
`define ARP_ADDR_RST         32'h0000_0000
`define CTRL_TWO_RST         2'h0
`define EVT_RST              2'h0

// ***************************************************************
// Frame codes and timing
// ***************************************************************
`define ETH_TYPE_ARP         16'h0806
`define IP_PROTO_TCP         8'h06
`define MAC_BROADCAST        48'hffff_ffff_ffff
`define APB_WAIT_CYCLES      1

`endif

// >>> wildcard_field_match.v
// Purpose : Compare one frame field against one configured value
// Assumes : Configured value of all zeros means "match anything"
// Notes   : Pure combinational; width set per instance
`timescale 1ns/1ps

module wildcard_field_match
#(
   parameter W = 16
)
(
   input  wire [W-1:0] cfg_value,   // Software-set reference
   input  wire [W-1:0] frame_value, // Field taken from the frame
   output wire         hit          // Field accepted
);

   // ***************************************************************
   // Compare
   // ***************************************************************
   // Zero reference skips the check and counts as a match
   assign hit = (cfg_value == {W{1'b0}}) || (cfg_value == frame_value);

endmodule

// >>> wake_event_regs.v
// Purpose : Sticky event status, enable mask and level interrupt
// Assumes : Set, clear and enable strobes are single cycle
// Notes   : A set in the clear cycle wins so no event is lost
`timescale 1ns/1ps
`include "wake_syn_arp_map.vh"

module wake_event_regs
(
   input  wire              clk,      // System clock
   input  wire              srst,     // Synchronous reset, high
   input  wire [`EVT_W-1:0] evt_set,  // Event pulses
   input  wire              clr_wr,   // Write to clear register
   input  wire              en_wr,    // Write to enable register
   input  wire [`EVT_W-1:0] wdata,    // Write data low bits
   output reg  [`EVT_W-1:0] status,   // Sticky event bits
   output reg  [`EVT_W-1:0] enable,   // Interrupt mask
   output reg               irq       // Level interrupt
);

   // Next-state terms
   reg [`EVT_W-1:0] next_status;

   // ***************************************************************
   // Status update
   // ***************************************************************
   // Clear first, then set, so a same-cycle event survives
   always @*
   begin
      next_status = status;
      if (clr_wr)
      begin
         next_status = next_status & ~wdata;
      end
      next_status = next_status | evt_set;
   end

   // ***************************************************************
   // Registers
   // ***************************************************************
   // Irq follows the stored state one cycle behind status
   always @(posedge clk)
   begin
      if (srst)
      begin
         status <= `EVT_RST;
         enable <= `EVT_RST;
         irq    <= 1'b0;
      end
      else
      begin
         status <= next_status;
         if (en_wr)
         begin
            enable <= wdata;
         end
         irq <= |(status & enable);
      end
   end

endmodule

// >>> wake_syn_arp_matcher.v
// Purpose : Match parsed receive frames for IPv6 SYN wake and ARP reply
// Assumes : Parser gives one header strobe and one end strobe per frame
// Notes   : APB slave, one wait state, all outputs from flip-flops
`timescale 1ns/1ps
`include "wake_syn_arp_map.vh"

module wake_syn_arp_matcher
(
   input  wire        SYS_CLK,           // System clock, 20 MHz
   input  wire        SRST,              // Synchronous reset, high
   input  wire        PSEL,              // APB select
   input  wire        PENABLE,           // APB access phase
   input  wire        PWRITE,            // APB direction
   input  wire [11:0] PADDR,             // APB byte address
   input  wire [31:0] PWDATA,            // APB write data
   output reg  [31:0] PRDATA,            // APB read data
   output reg         PREADY,            // APB ready
   output reg         PSLVERR,           // APB error, unmapped
   input  wire        SUSPEND_ZERO,      // Power manager: suspend zero
   input  wire [47:0] DEV_MAC_ADDR,      // Device MAC address
   input  wire        HDR_VALID,         // Parsed header strobe
   input  wire [47:0] HDR_DEST_MAC,      // Destination MAC
   input  wire [15:0] HDR_ETH_TYPE,      // Ethernet type field
   input  wire        HDR_IS_V6,         // Frame carries IPv6
   input  wire [7:0]  HDR_V6_PROTO,      // Final next-header value
   input  wire        HDR_TCP_SYN,       // TCP SYN flag
   input  wire        HDR_V6_ADDR_MATCH, // IPv6 address compare result
   input  wire [15:0] HDR_SRC_PORT,      // TCP source port
   input  wire [15:0] HDR_DST_PORT,      // TCP destination port
   input  wire [31:0] HDR_ARP_SENDER_ADDRESS_REGISTER,       // ARP sender protocol addr
   input  wire [31:0] HDR_ARP_TARGET_ADDRESS_REGISTER,       // ARP target protocol addr
   input  wire        FRAME_END,         // End of frame strobe
   input  wire        FRAME_ERR,         // Frame error, with FRAME_END
   output reg         SYN_WAKE,          // Wakeup pulse
   output reg         ARP_REPLY_REQ,     // Reply request to transmit
   output wire        IRQ                // Level interrupt
);

   // ***************************************************************
   // Local constants
   // ***************************************************************
   localparam [1:0] ST_IDLE = 2'b01;  // Waiting for a header
   localparam [1:0] ST_HELD = 2'b10;  // Header seen, waiting for end

   // ***************************************************************
   // Declarations
   // ***************************************************************
   reg  [31:0] v6_syn_port_register;        // Dest and source ports
   reg  [31:0] arp_sender_address_register; // Sender protocol address
   reg  [31:0] arp_target_address_register; // Target protocol address
   reg  [1:0]  wake_control_status_two;     // Wake and offload enables
   reg  [1:0]  state;                       // Frame tracking state
   reg  [1:0]  next_state;                  // Next frame state
   reg         syn_pend;                    // SYN match awaiting end
   reg         next_syn_pend;               // Next SYN pending
   reg         arp_pend;                    // ARP match awaiting end
   reg         next_arp_pend;               // Next ARP pending
   reg         next_syn_wake;               // Next wake pulse
   reg         next_arp_req;                // Next reply pulse
   reg  [31:0] next_prdata;                 // Read mux result
   reg         next_pslverr;                // Unmapped flag
   wire [1:0]  port_hit;                    // Source, dest port hits
   wire [1:0]  arp_hit;                     // Sender, target hits
   wire [31:0] frame_ports;                 // Frame ports, reg layout
   wire [63:0] frame_arp;                   // Frame addrs, reg layout
   wire [63:0] cfg_arp;                     // Configured ARP addrs
   wire        v6_syn_wake_enable;          // SYN wake enabled
   wire        arp_offload_enable;          // ARP offload enabled
   wire        own_mac;                     // Dest MAC is ours
   wire        v6_dest_ok;                  // SYN MAC filter passed
   wire        arp_dest_ok;                 // ARP MAC filter passed
   wire        syn_match;                   // Whole SYN match
   wire        arp_match;                   // Whole ARP match
   wire        apb_access;                  // Access phase active
   wire        apb_write;                   // Write commit cycle
   wire [`EVT_W-1:0] evt_status;            // Sticky events
   wire [`EVT_W-1:0] evt_enable;            // Event mask

   // ***************************************************************
   // Functions
   // ***************************************************************
   // Address decode, shared by read mux and write strobes
   function addr_is;
      input [11:0] addr;
      input [11:0] ofs;
      begin
         addr_is = (addr == ofs);
      end
   endfunction

   // Broadcast test, shared by both MAC filters
   function is_broadcast;
      input [47:0] mac;
      begin
         is_broadcast = (mac == `MAC_BROADCAST);
      end
   endfunction

   // ***************************************************************
   // Enables and MAC filters
   // ***************************************************************
   assign v6_syn_wake_enable = wake_control_status_two[`CTRL_SYN_WAKE_BIT];
   assign arp_offload_enable =
      wake_control_status_two[`CTRL_ARP_OFFLOAD_BIT];
   assign own_mac = (HDR_DEST_MAC == DEV_MAC_ADDR);
   // Group bit (first transmitted bit) marks multicast
   assign v6_dest_ok = own_mac || HDR_DEST_MAC[40] ||
                       is_broadcast(HDR_DEST_MAC);
   // ARP takes no multicast, only own or broadcast
   assign arp_dest_ok = own_mac || is_broadcast(HDR_DEST_MAC);

   // ***************************************************************
   // Field comparators
   // ***************************************************************
   assign frame_ports = {HDR_DST_PORT, HDR_SRC_PORT};
   assign frame_arp   = {HDR_ARP_TARGET_ADDRESS_REGISTER, HDR_ARP_SENDER_ADDRESS_REGISTER};
   assign cfg_arp     = {arp_target_address_register,
                         arp_sender_address_register};

   // Index 0 is source / sender, index 1 is dest / target
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1)
      begin : g_cmp
         // Zero port field skips its compare
         wildcard_field_match #(.W(16)) u_port
         (
            .cfg_value   (v6_syn_port_register[gi*16 +: 16]),
            .frame_value (frame_ports[gi*16 +: 16]),
            .hit         (port_hit[gi])
         );
         // Zero address skips its compare
         wildcard_field_match #(.W(32)) u_arp
         (
            .cfg_value   (cfg_arp[gi*32 +: 32]),
            .frame_value (frame_arp[gi*32 +: 32]),
            .hit         (arp_hit[gi])
         );
      end
   endgenerate

   // ***************************************************************
   // Match terms
   // ***************************************************************
   // Gate order: enable and state, MAC, TCP, then SYN/addr/ports
   assign syn_match = v6_syn_wake_enable && SUSPEND_ZERO &&
                      HDR_IS_V6 && v6_dest_ok &&
                      (HDR_V6_PROTO == `IP_PROTO_TCP) &&
                      HDR_TCP_SYN && HDR_V6_ADDR_MATCH &&
                      (&port_hit);
   assign arp_match = arp_offload_enable &&
                      (HDR_ETH_TYPE == `ETH_TYPE_ARP) &&
                      arp_dest_ok && (&arp_hit);

   // ***************************************************************
   // Frame tracking
   // ***************************************************************
   // Matches are held until the error status arrives at frame end
   always @*
   begin
      next_state    = state;
      next_syn_pend = syn_pend;
      next_arp_pend = arp_pend;
      next_syn_wake = 1'b0;
      next_arp_req  = 1'b0;
      case (state)
         ST_IDLE:
         begin
            if (HDR_VALID && FRAME_END)
            begin
               // Short frame: header and end together
               next_syn_wake = syn_match && !FRAME_ERR;
               next_arp_req  = arp_match && !FRAME_ERR;
            end
            else if (HDR_VALID)
            begin
               next_syn_pend = syn_match;
               next_arp_pend = arp_match;
               next_state    = ST_HELD;
            end
         end
         ST_HELD:
         begin
            // A second header before the end is ignored
            if (FRAME_END)
            begin
               next_syn_wake = syn_pend && !FRAME_ERR;
               next_arp_req  = arp_pend && !FRAME_ERR;
               next_syn_pend = 1'b0;
               next_arp_pend = 1'b0;
               next_state    = ST_IDLE;
            end
         end
         default:
         begin
            // Recover from an illegal code
            next_state    = ST_IDLE;
            next_syn_pend = 1'b0;
            next_arp_pend = 1'b0;
         end
      endcase
   end

   // Frame state and output pulses
   always @(posedge SYS_CLK)
   begin
      if (SRST)
      begin
         state         <= ST_IDLE;
         syn_pend      <= 1'b0;
         arp_pend      <= 1'b0;
         SYN_WAKE      <= 1'b0;
         ARP_REPLY_REQ <= 1'b0;
      end
      else
      begin
         state         <= next_state;
         syn_pend      <= next_syn_pend;
         arp_pend      <= next_arp_pend;
         SYN_WAKE      <= next_syn_wake;
         ARP_REPLY_REQ <= next_arp_req;
      end
   end

   // ***************************************************************
   // APB slave
   // ***************************************************************
   // One wait state keeps PRDATA and PREADY straight from flops
   assign apb_access = PSEL && PENABLE;
   assign apb_write  = apb_access && PREADY && PWRITE;

   // Read mux and unmapped detect
   always @*
   begin
      next_prdata  = 32'h0000_0000;
      next_pslverr = 1'b0;
      if (addr_is(PADDR, `V6_SYN_PORT_OFS))
      begin
         next_prdata = v6_syn_port_register;
      end
      else if (addr_is(PADDR, `ARP_SENDER_OFS))
      begin
         next_prdata = arp_sender_address_register;
      end
      else if (addr_is(PADDR, `ARP_TARGET_OFS))
      begin
         next_prdata = arp_target_address_register;
      end
      else if (addr_is(PADDR, `WAKE_CTRL_TWO_OFS))
      begin
         next_prdata = {30'h0000_0000, wake_control_status_two};
      end
      else if (addr_is(PADDR, `WAKE_STATUS_OFS))
      begin
         next_prdata = {30'h0000_0000, evt_status};
      end
      else if (addr_is(PADDR, `WAKE_CLEAR_OFS))
      begin
         // Write-only, reads as zero
         next_prdata = 32'h0000_0000;
      end
      else if (addr_is(PADDR, `WAKE_ENABLE_OFS))
      begin
         next_prdata = {30'h0000_0000, evt_enable};
      end
      else
      begin
         // Unmapped: zero data and an error
         next_pslverr = 1'b1;
      end
   end

   // Handshake, read capture and register writes
   always @(posedge SYS_CLK)
   begin
      if (SRST)
      begin
         PREADY                      <= 1'b0;
         PRDATA                      <= 32'h0000_0000;
         PSLVERR                     <= 1'b0;
         v6_syn_port_register        <= `V6_SYN_PORT_RST;
         arp_sender_address_register <= `ARP_ADDR_RST;
         arp_target_address_register <= `ARP_ADDR_RST;
         wake_control_status_two     <= `CTRL_TWO_RST;
      end
      else
      begin
         // Ready rises in the second access cycle, drops after
         PREADY  <= apb_access && !PREADY;
         PSLVERR <= apb_access && !PREADY && next_pslverr;
         if (apb_access && !PREADY && !PWRITE)
         begin
            PRDATA <= next_prdata;
         end
         else
         begin
            // Read data stands only in the ready cycle of a read
            PRDATA <= 32'h0000_0000;
         end
         // Writes commit only at the ready edge
         if (apb_write && addr_is(PADDR, `V6_SYN_PORT_OFS))
         begin
            v6_syn_port_register <= PWDATA;
         end
         if (apb_write && addr_is(PADDR, `ARP_SENDER_OFS))
         begin
            arp_sender_address_register <= PWDATA;
         end
         if (apb_write && addr_is(PADDR, `ARP_TARGET_OFS))
         begin
            arp_target_address_register <= PWDATA;
         end
         if (apb_write && addr_is(PADDR, `WAKE_CTRL_TWO_OFS))
         begin
            wake_control_status_two <= PWDATA[1:0];
         end
      end
   end

   // ***************************************************************
   // Event status and interrupt
   // ***************************************************************
   // Events are logged from the same pulses that leave the block
   wake_event_regs u_evt
   (
      .clk     (SYS_CLK),
      .srst    (SRST),
      .evt_set ({ARP_REPLY_REQ, SYN_WAKE}),
      .clr_wr  (apb_write && addr_is(PADDR, `WAKE_CLEAR_OFS)),
      .en_wr   (apb_write && addr_is(PADDR, `WAKE_ENABLE_OFS)),
      .wdata   (PWDATA[`EVT_W-1:0]),
      .status  (evt_status),
      .enable  (evt_enable),
      .irq     (IRQ)
   );

endmodule

// >>> wake_syn_arp_matcher_props.sv
// Purpose : Port-level checks of the SYN and ARP frame matcher
// Assumes : One clock, reset high and synchronous
// Notes   : Bound to the top module from the testbench
`timescale 1ns/1ps

module wake_syn_arp_matcher_props
(
   input wire        SYS_CLK,
   input wire        SRST,
   input wire        PSEL,
   input wire        PENABLE,
   input wire        PREADY,
   input wire        HDR_VALID,
   input wire [15:0] HDR_ETH_TYPE,
   input wire [7:0]  HDR_V6_PROTO,
   input wire        SUSPEND_ZERO,
   input wire        FRAME_END,
   input wire        FRAME_ERR,
   input wire        SYN_WAKE,
   input wire        ARP_REPLY_REQ
);
   // ****
   // Steps
   // ****
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SRST);
   sequence s_setup; PSEL && !PENABLE; endsequence
   sequence s_access; PSEL && PENABLE; endsequence
   // Header and clean end in one cycle
   sequence s_hdr_end; HDR_VALID && FRAME_END && !FRAME_ERR; endsequence

   // ****
   // Properties
   // ****
   property p_ready_one_wait;
      s_setup ##1 s_access |=> PREADY;
   endproperty
   property p_ready_pulse;
      PREADY |=> !PREADY;
   endproperty
   property p_syn_single;
      SYN_WAKE |=> !SYN_WAKE;
   endproperty
   property p_arp_single;
      ARP_REPLY_REQ |=> !ARP_REPLY_REQ;
   endproperty
   property p_syn_cause;
      SYN_WAKE |-> $past(FRAME_END) && !$past(FRAME_ERR);
   endproperty
   property p_arp_cause;
      ARP_REPLY_REQ |-> $past(FRAME_END) && !$past(FRAME_ERR);
   endproperty
   property p_syn_suspend;
      s_hdr_end ##0 !SUSPEND_ZERO |=> !SYN_WAKE;
   endproperty
   property p_syn_proto;
      s_hdr_end ##0 (HDR_V6_PROTO != 8'h06) |=> !SYN_WAKE;
   endproperty
   property p_arp_type;
      s_hdr_end ##0 (HDR_ETH_TYPE != 16'h0806) |=> !ARP_REPLY_REQ;
   endproperty
   property p_err_quiet;
      FRAME_END && FRAME_ERR |=> !SYN_WAKE && !ARP_REPLY_REQ;
   endproperty

   a_ready_one_wait: assert property (p_ready_one_wait)
      else $error("ready not one cycle after access");
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("ready longer than one cycle");
   a_syn_single: assert property (p_syn_single)
      else $error("wake pulse too long");
   a_arp_single: assert property (p_arp_single)
      else $error("reply request too long");
   a_syn_cause: assert property (p_syn_cause)
      else $error("wake without clean frame end");
   a_arp_cause: assert property (p_arp_cause)
      else $error("reply without clean frame end");
   a_syn_suspend: assert property (p_syn_suspend)
      else $error("wake outside suspend zero");
   a_syn_proto: assert property (p_syn_proto)
      else $error("wake for non-TCP frame");
   a_arp_type: assert property (p_arp_type)
      else $error("reply for non-ARP type");
   a_err_quiet: assert property (p_err_quiet)
      else $error("pulse after errored frame");
endmodule

// >>> mac_rx_model.sv
// Purpose : Receive-path stand-in delivering parsed frames
// Assumes : One header strobe and one end strobe per frame
// Notes   : Idle fields show inverted data, never the last value
`timescale 1ns/1ps

module mac_rx_model
(
   input  wire         clk,       // System clock
   output reg          hdr_valid, // Header strobe
   output reg  [170:0] hdr,       // Packed header fields
   output reg          frame_end, // End strobe
   output reg          frame_err  // Error flag
);
   // ****
   // Idle values
   // ****
   initial
   begin
      hdr_valid = 1'b0;
      hdr = {171{1'b0}};
      frame_end = 1'b0;
      frame_err = 1'b0;
   end

   // One frame; s puts the end in the header cycle
   task send(input [170:0] v, input e, input s);
   begin
      @(posedge clk);
      hdr <= v;
      hdr_valid <= 1'b1;
      frame_end <= s;
      frame_err <= e;
      @(posedge clk);
      hdr_valid <= 1'b0;
      hdr <= ~v; // Stale fields turn to junk
      if (!s)
      begin
         frame_end <= 1'b1;
         @(posedge clk);
      end
      frame_end <= 1'b0;
      frame_err <= ~e;
   end
   endtask
endmodule

// >>> wake_syn_arp_matcher_tb.sv
// Purpose : Self-checking bench for the SYN and ARP frame matcher
// Assumes : APB one word per register, seed fixed
// Notes   : Expected pulses computed from configuration and frame
`timescale 1ns/1ps

module wake_syn_arp_matcher_tb;
   reg          clk, srst, psel, penable, pwrite, susp, err, e, s;
   reg  [11:0]  paddr;
   reg  [31:0]  pwdata, ports, spa, tpa, rd;
   reg  [47:0]  mac;
   reg  [1:0]   ctrl, en, st, x;
   reg  [170:0] v;
   wire [31:0]  prdata;
   wire [170:0] h;
   wire         pready, pslverr, syn_wake, arp_req, irq, hv, fe, ferr;
   integer      mismatches, n_checks, i, pass;
   integer      cyc = 0;

   wake_syn_arp_matcher wake_syn_arp_matcher_inst
   (
      .SYS_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .SUSPEND_ZERO(susp),
      .DEV_MAC_ADDR(mac), .HDR_VALID(hv), .HDR_DEST_MAC(h[170:123]),
      .HDR_ETH_TYPE(h[122:107]), .HDR_IS_V6(h[106]),
      .HDR_V6_PROTO(h[105:98]), .HDR_TCP_SYN(h[97]),
      .HDR_V6_ADDR_MATCH(h[96]), .HDR_SRC_PORT(h[95:80]),
      .HDR_DST_PORT(h[79:64]), .HDR_ARP_SENDER_ADDRESS_REGISTER(h[63:32]),
      .HDR_ARP_TARGET_ADDRESS_REGISTER(h[31:0]), .FRAME_END(fe), .FRAME_ERR(ferr),
      .SYN_WAKE(syn_wake), .ARP_REPLY_REQ(arp_req), .IRQ(irq)
   );
   mac_rx_model mac_rx_model_inst
   (
      .clk(clk), .hdr_valid(hv), .hdr(h), .frame_end(fe), .frame_err(ferr)
   );

   // ****
   // Clock and hang guard
   // ****
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      if (cyc == 40000)
      begin
         mismatches = mismatches + 1;
         summarize;
      end
   end

   // ****
   // Helpers
   // ****
   // One bit wider than a data word so a flag can ride with read data
   task chk(input [32:0] got, input [32:0] exp);
   begin
      n_checks = n_checks + 1;
      if (got !== exp)
      begin
         mismatches = mismatches + 1;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   end
   endtask

   // APB transfer; waits on ready, no fixed latency assumed
   task apb(input w, input [11:0] a, input [31:0] d);
   begin
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask

   // Bit 0 wake, bit 1 reply
   function [1:0] expect_out(input [170:0] f, input fe_err);
      reg [47:0] dm;
   begin
      dm = f[170:123];
      expect_out[0] = ctrl[0] & susp & f[106] & (dm == mac | dm[40] | &dm)
         & f[105:98] == 8'h06 & f[97] & f[96] & !fe_err
         & (ports[15:0] == 16'h0 | ports[15:0] == f[95:80])
         & (ports[31:16] == 16'h0 | ports[31:16] == f[79:64]);
      expect_out[1] = ctrl[1] & f[122:107] == 16'h0806 & !fe_err
         & (dm == mac | &dm) & (spa == 32'h0 | spa == f[63:32])
         & (tpa == 32'h0 | tpa == f[31:0]);
   end
   endfunction

   // Mostly matching frame, sometimes one bit spoiled
   function [170:0] make_frame(input integer k);
      reg [47:0] dm;
      reg [31:0] r;
   begin
      r = $urandom;
      case ($urandom % 3)
         0: dm = mac;
         1: dm = 48'hffff_ffff_ffff;
         default: dm = {r, r[15:0]} | 48'h0100_0000_0000;
      endcase
      make_frame = {dm, ($urandom % 2) ? 16'h0806 : 16'h86dd, 1'b1,
         ($urandom % 4) ? 8'h06 : 8'h11, 2'b11,
         ports[15:0] != 16'h0 ? ports[15:0] : r[15:0],
         ports[31:16] != 16'h0 ? ports[31:16] : r[31:16],
         spa != 32'h0 ? spa : $urandom, tpa != 32'h0 ? tpa : $urandom};
      if (k < 171)
         make_frame[k] = ~make_frame[k];
   end
   endfunction

   task summarize;
   begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   end
   endtask

   // ****
   // Main sequence
   // ****
   initial
   begin
      srst = 1'b1;
      {psel, penable, pwrite, susp} = 4'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      mismatches = 0;
      n_checks = 0;
      i = $urandom(14);
      mac = {$urandom, 16'h1234} & ~48'h0100_0000_0000;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      // Reset values and read-back of the three registers
      for (i = 0; i < 3; i = i + 1)
      begin
         apb(1'b0, 12'(12'h6bc + 4 * i), 32'h0);
         chk(rd, 32'h0);
         v[31:0] = $urandom;
         apb(1'b1, 12'(12'h6bc + 4 * i), v[31:0]);
         apb(1'b0, 12'(12'h6bc + 4 * i), 32'h0);
         chk(rd, v[31:0]);
      end
      apb(1'b1, 12'h700, $urandom);
      chk(err, 1'b1);
      apb(1'b0, 12'h700, 32'h0);
      chk({err, rd}, {1'b1, 32'h0});
      $display("register test done");
      // Random frames, SYN interrupt masked then both open
      for (pass = 0; pass < 2; pass = pass + 1)
      begin
         en = pass ? 2'h3 : 2'h2;
         apb(1'b1, 12'h6d4, {30'h0, en});
         st = 2'h0;
         repeat (150)
         begin
            ports = $urandom;
            if ($urandom % 2) ports[15:0] = 16'h0;
            if ($urandom % 2) ports[31:16] = 16'h0;
            spa = ($urandom % 2) ? $urandom : 32'h0;
            tpa = ($urandom % 2) ? $urandom : 32'h0;
            ctrl = ($urandom % 4) ? 2'h3 : 2'($urandom);
            apb(1'b1, 12'h6bc, ports);
            apb(1'b1, 12'h6c0, spa);
            apb(1'b1, 12'h6c4, tpa);
            apb(1'b1, 12'h6c8, {30'h0, ctrl});
            susp <= ($urandom % 4) != 0;
            v = make_frame(($urandom % 2) ? 171 : $urandom % 171);
            e = ($urandom % 8) == 0;
            s = $urandom;
            mac_rx_model_inst.send(v, e, s);
            @(posedge clk);
            x = expect_out(v, e);
            chk(syn_wake, x[0]);
            chk(arp_req, x[1]);
            st = st | x;
         end
         repeat (3) @(posedge clk);
         chk(irq, |(st & en));
         apb(1'b0, 12'h6cc, 32'h0);
         chk(rd, {30'h0, st});
         apb(1'b1, 12'h6d0, 32'h3);
         apb(1'b0, 12'h6cc, 32'h0);
         chk({irq, rd}, 33'h0);
         $display("frame pass %0d done", pass);
      end
      summarize;
   end
endmodule

bind wake_syn_arp_matcher wake_syn_arp_matcher_props
   wake_syn_arp_matcher_props_inst
(
   .SYS_CLK, .SRST, .PSEL, .PENABLE, .PREADY, .HDR_VALID, .HDR_ETH_TYPE,
   .HDR_V6_PROTO, .SUSPEND_ZERO, .FRAME_END, .FRAME_ERR, .SYN_WAKE,
   .ARP_REPLY_REQ
);
